// ==== dcf_channel.sv ====
// One FIFO channel: pin control, pointers, flags, registers and interrupt
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module dcf_channel (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic channel_reset_n_i,
	input wire logic [dcf_pkg::DATA_W-1:0] write_data_in_i,
	input wire logic write_enable_first_n_i,
	input wire logic write_enable_second_or_offset_load_i,
	input wire logic read_enable_first_n_i,
	input wire logic read_enable_second_n_i,
	input wire logic output_drive_enable_n_i,
	output logic [dcf_pkg::DATA_W-1:0] read_data_out_o,
	output logic read_data_out_oe_o,
	output logic empty_flag_out_n_o,
	output logic full_flag_out_n_o,
	output logic almost_empty_flag_out_n_o,
	output logic almost_full_flag_out_n_o,
	input wire logic [dcf_pkg::REG_AW-1:0] reg_addr_i,
	input wire logic [dcf_pkg::REG_DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [dcf_pkg::REG_DW-1:0] reg_rdata_o,
	output logic irq_o
);

	localparam int AW = dcf_pkg::ADDR_W;
	localparam int PW = dcf_pkg::PTR_W;
	localparam int DW = dcf_pkg::DATA_W;
	localparam int IW = dcf_pkg::IRQ_W;

	// Pin synchronisers; only the second stage is read
	logic [dcf_pkg::SYNC_W-1:0] pin_s1_reg;
	logic [dcf_pkg::SYNC_W-1:0] pin_s2_reg;
	wire logic [dcf_pkg::SYNC_W-1:0] pin_raw = {write_data_in_i, write_enable_first_n_i,
		write_enable_second_or_offset_load_i, read_enable_first_n_i, read_enable_second_n_i,
		output_drive_enable_n_i, channel_reset_n_i};

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_reg <= dcf_pkg::SYNC_RESET;
			pin_s2_reg <= dcf_pkg::SYNC_RESET;
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	wire logic [DW-1:0] wdata_s = pin_s2_reg[dcf_pkg::SYNC_W-1:6];
	wire logic we1_n_s = pin_s2_reg[5];
	wire logic we2_s = pin_s2_reg[4];
	wire logic re1_n_s = pin_s2_reg[3];
	wire logic re2_n_s = pin_s2_reg[2];
	wire logic oe_n_s = pin_s2_reg[1];
	wire logic chan_rst = ~pin_s2_reg[0];

	// Configuration strap, caught while the channel reset is held
	dcf_pkg::dcf_mode_t mode_reg;
	dcf_pkg::dcf_mode_t mode_next;
	assign mode_next = we2_s ? dcf_pkg::MODE_DUAL_WE : dcf_pkg::MODE_PROG;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_reg <= dcf_pkg::MODE_DUAL_WE;
		end else if (chan_rst) begin
			mode_reg <= mode_next;
		end
	end

	wire logic is_dual = (mode_reg == dcf_pkg::MODE_DUAL_WE);
	// In programmable mode the shared pin low means offsets are being accessed
	wire logic offset_load_control = ~is_dual & ~we2_s;
	wire logic wr_gate = is_dual ? we2_s : ~offset_load_control;

	// Pointers and their crossing copies
	logic [PW-1:0] wbin_reg;
	logic [PW-1:0] wgray_reg;
	logic [PW-1:0] rbin_reg;
	logic [PW-1:0] rgray_reg;
	logic [PW-1:0] wg_s1_reg;
	logic [PW-1:0] wg_s2_reg;
	logic [PW-1:0] rg_s1_reg;
	logic [PW-1:0] rg_s2_reg;
	logic ef_n_reg;
	logic ae_n_reg;
	logic ff_n_reg;
	logic af_n_reg;
	logic [AW-1:0] empty_off_reg;
	logic [AW-1:0] full_off_reg;

	wire logic wr_req = ~we1_n_s & wr_gate;
	wire logic wr_ok = wr_req & ff_n_reg & ~chan_rst;
	wire logic rd_req = ~re1_n_s & ~re2_n_s;
	wire logic rd_ok = rd_req & ef_n_reg & ~chan_rst;

	wire logic [PW-1:0] wbin_next = wbin_reg + PW'(wr_ok);
	wire logic [PW-1:0] rbin_next = rbin_reg + PW'(rd_ok);
	wire logic [PW-1:0] rbin_seen = dcf_pkg::gray2bin(rg_s2_reg);
	wire logic [PW-1:0] wbin_seen = dcf_pkg::gray2bin(wg_s2_reg);

	// Levels as each side sees them; the far pointer lags, so flags stay safe
	wire logic [PW-1:0] w_level_next = wbin_next - rbin_seen;
	wire logic [PW-1:0] r_level_next = wbin_seen - rbin_next;
	wire logic [PW-1:0] w_level = wbin_reg - rbin_seen;
	wire logic [PW-1:0] r_level = wbin_seen - rbin_reg;
	wire logic [PW-1:0] w_space_next = dcf_pkg::DEPTH - w_level_next;

	wire logic ff_n_next = (w_level_next != dcf_pkg::DEPTH);
	wire logic af_n_next = (w_space_next > {1'b0, full_off_reg});
	wire logic ef_n_next = (r_level_next != '0);
	wire logic ae_n_next = (r_level_next > {1'b0, empty_off_reg});

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wbin_reg <= '0;
			wgray_reg <= '0;
			ff_n_reg <= 1'b1;
			af_n_reg <= 1'b1;
		end else if (chan_rst) begin
			wbin_reg <= '0;
			wgray_reg <= '0;
			ff_n_reg <= 1'b1;
			af_n_reg <= 1'b1;
		end else begin
			wbin_reg <= wbin_next;
			wgray_reg <= dcf_pkg::bin2gray(wbin_next);
			ff_n_reg <= ff_n_next;
			af_n_reg <= af_n_next;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rbin_reg <= '0;
			rgray_reg <= '0;
			ef_n_reg <= 1'b0;
			ae_n_reg <= 1'b0;
		end else if (chan_rst) begin
			rbin_reg <= '0;
			rgray_reg <= '0;
			ef_n_reg <= 1'b0;
			ae_n_reg <= 1'b0;
		end else begin
			rbin_reg <= rbin_next;
			rgray_reg <= dcf_pkg::bin2gray(rbin_next);
			ef_n_reg <= ef_n_next;
			ae_n_reg <= ae_n_next;
		end
	end

	// Two-flop crossing even with tied clocks, so split clocks drop in unchanged
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wg_s1_reg <= '0;
			wg_s2_reg <= '0;
			rg_s1_reg <= '0;
			rg_s2_reg <= '0;
		end else if (chan_rst) begin
			wg_s1_reg <= '0;
			wg_s2_reg <= '0;
			rg_s1_reg <= '0;
			rg_s2_reg <= '0;
		end else begin
			wg_s1_reg <= wgray_reg;
			wg_s2_reg <= wg_s1_reg;
			rg_s1_reg <= rgray_reg;
			rg_s2_reg <= rg_s1_reg;
		end
	end

	dcf_ram u_ram (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.wr_en_i(wr_ok),
		.wr_addr_i(wbin_reg[AW-1:0]),
		.wr_data_i(wdata_s),
		.rd_en_i(rd_ok),
		.rd_addr_i(rbin_reg[AW-1:0]),
		.rd_data_o(read_data_out_o)
	);

	assign read_data_out_oe_o = ~oe_n_s;
	assign empty_flag_out_n_o = ef_n_reg;
	assign full_flag_out_n_o = ff_n_reg;
	assign almost_empty_flag_out_n_o = ae_n_reg;
	assign almost_full_flag_out_n_o = af_n_reg;

	// Register port
	wire logic wr_empty_off = reg_wr_i & (reg_addr_i == dcf_pkg::REG_EMPTY_OFF);
	wire logic wr_full_off = reg_wr_i & (reg_addr_i == dcf_pkg::REG_FULL_OFF);
	wire logic wr_irq_stat = reg_wr_i & (reg_addr_i == dcf_pkg::REG_IRQ_STATUS);
	wire logic wr_irq_mask = reg_wr_i & (reg_addr_i == dcf_pkg::REG_IRQ_MASK);
	// Offsets only load in programmable mode; dual mode keeps the defaults
	wire logic off_load_ok = ~is_dual & ~chan_rst;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			empty_off_reg <= dcf_pkg::OFFSET_DEFAULT;
			full_off_reg <= dcf_pkg::OFFSET_DEFAULT;
		end else if (chan_rst) begin
			empty_off_reg <= dcf_pkg::OFFSET_DEFAULT;
			full_off_reg <= dcf_pkg::OFFSET_DEFAULT;
		end else begin
			if (wr_empty_off && off_load_ok) begin
				empty_off_reg <= reg_wdata_i[AW-1:0];
			end
			if (wr_full_off && off_load_ok) begin
				full_off_reg <= reg_wdata_i[AW-1:0];
			end
		end
	end

	// Interrupt events; a new event wins over a write-one clear
	logic [IW-1:0] irq_stat_reg;
	logic [IW-1:0] irq_stat_next;
	logic [IW-1:0] irq_mask_reg;
	wire logic [IW-1:0] irq_event = {rd_req & ~ef_n_reg & ~chan_rst,
		wr_req & ~ff_n_reg & ~chan_rst,
		ef_n_reg & ~ef_n_next & ~chan_rst,
		ff_n_reg & ~ff_n_next & ~chan_rst};
	wire logic [IW-1:0] irq_clear = wr_irq_stat ? reg_wdata_i[IW-1:0] : '0;
	assign irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_event;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= dcf_pkg::IRQ_MASK_RESET;
		end else begin
			irq_stat_reg <= irq_stat_next;
			if (wr_irq_mask) begin
				irq_mask_reg <= reg_wdata_i[IW-1:0];
			end
		end
	end

	assign irq_o = |(irq_stat_reg & irq_mask_reg);

	logic [dcf_pkg::REG_DW-1:0] rd_mux;
	always_comb begin
		case (reg_addr_i)
			dcf_pkg::REG_FLAGS: rd_mux = {26'h0, offset_load_control, is_dual,
				af_n_reg, ae_n_reg, ff_n_reg, ef_n_reg};
			dcf_pkg::REG_EMPTY_OFF: rd_mux = {24'h0, empty_off_reg};
			dcf_pkg::REG_FULL_OFF: rd_mux = {24'h0, full_off_reg};
			dcf_pkg::REG_LEVEL: rd_mux = {23'h0, r_level};
			dcf_pkg::REG_IRQ_STATUS: rd_mux = {28'h0, irq_stat_reg};
			dcf_pkg::REG_IRQ_MASK: rd_mux = {28'h0, irq_mask_reg};
			default: rd_mux = '0;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_mux : '0;
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence oe_pin_low_held;
		!output_drive_enable_n_i [*3];
	endsequence

	sequence oe_pin_high_held;
		output_drive_enable_n_i [*3];
	endsequence

	chk_full_blocks_write: assert property (
		(!ff_n_reg && !chan_rst) |=> (wbin_reg == $past(wbin_reg)))
		else $error("write pointer moved while full");

	chk_empty_blocks_read: assert property (
		(!ef_n_reg && !chan_rst) |=> ($stable(rbin_reg) && $stable(read_data_out_o)))
		else $error("read side moved while empty");

	chk_dual_second_gate: assert property (
		(is_dual && !we2_s && !chan_rst) |=> (wbin_reg == $past(wbin_reg)))
		else $error("write taken without second enable");

	chk_write_advance: assert property (
		(!we1_n_s && wr_gate && ff_n_reg && !chan_rst) |=> (wbin_reg == PW'($past(wbin_reg) + 1)))
		else $error("accepted write did not advance pointer");

	chk_read_advance: assert property (
		(!re1_n_s && !re2_n_s && ef_n_reg && !chan_rst) |=> (rbin_reg == PW'($past(rbin_reg) + 1)))
		else $error("accepted read did not advance pointer");

	chk_output_drive_on: assert property (
		oe_pin_low_held |-> read_data_out_oe_o)
		else $error("output not driven with enable low");

	chk_output_drive_off: assert property (
		oe_pin_high_held |-> !read_data_out_oe_o)
		else $error("output driven with enable high");

	chk_reset_flag_state: assert property (
		chan_rst |=> (ff_n_reg && af_n_reg && !ef_n_reg && !ae_n_reg &&
			rbin_reg == '0 && wbin_reg == '0))
		else $error("channel reset left wrong state");

	chk_strap_mode_capture: assert property (
		chan_rst |=> (is_dual == $past(we2_s)))
		else $error("mode strap not captured");

	chk_empty_flag_level: assert property (
		(ef_n_reg && !chan_rst) |-> (r_level != '0))
		else $error("empty flag high with nothing stored");

	chk_full_flag_level: assert property (
		(ff_n_reg && !chan_rst) |-> (w_level != dcf_pkg::DEPTH))
		else $error("full flag high with channel full");

	chk_almost_empty_level: assert property (
		(ae_n_reg && !chan_rst && $stable(empty_off_reg)) |-> (r_level > {1'b0, empty_off_reg}))
		else $error("almost-empty high at or below offset");

	chk_almost_full_level: assert property (
		(af_n_reg && !chan_rst && $stable(full_off_reg)) |->
			((dcf_pkg::DEPTH - w_level) > {1'b0, full_off_reg}))
		else $error("almost-full high at or below offset");

endmodule : dcf_channel

// ==== dcf_far_end.sv ====
// Writer and reader logic that faces the pins of one FIFO channel
`timescale 1ns/1ps
module dcf_far_end (
	input wire logic push_i,
	input wire logic [dcf_pkg::DATA_W-1:0] word_i,
	input wire logic load_i,
	input wire logic pop_i,
	input wire logic pop_one_i,
	output logic [dcf_pkg::DATA_W-1:0] write_data_o,
	output logic write_enable_first_n_o,
	output logic write_enable_second_or_offset_load_o,
	output logic read_enable_first_n_o,
	output logic read_enable_second_n_o
);
	// Words are strobed by the first enable; the second pin must also be high
	assign write_enable_first_n_o = !push_i;
	// Level set by the bench: high to write, low through offset access
	assign write_enable_second_or_offset_load_o = load_i;
	// Idle bus shows the inverse, so a stale word never looks valid
	assign write_data_o = push_i ? word_i : ~word_i;
	assign read_enable_first_n_o = !(pop_i || pop_one_i);
	assign read_enable_second_n_o = !pop_i;
endmodule : dcf_far_end

// ==== dcf_pkg.sv ====
// Constants, types and helpers for the dual-clock FIFO channel
package dcf_pkg;

	localparam int DATA_W = 9;
	localparam int ADDR_W = 8;
	localparam int PTR_W = ADDR_W + 1;
	localparam logic [PTR_W-1:0] DEPTH = 9'h100;
	localparam logic [ADDR_W-1:0] OFFSET_DEFAULT = 8'h07;
	localparam int SYNC_W = DATA_W + 6;

	// Register indices on the plain register port
	localparam int REG_AW = 4;
	localparam int REG_DW = 32;
	localparam logic [REG_AW-1:0] REG_FLAGS = 4'h0;
	localparam logic [REG_AW-1:0] REG_EMPTY_OFF = 4'h1;
	localparam logic [REG_AW-1:0] REG_FULL_OFF = 4'h2;
	localparam logic [REG_AW-1:0] REG_LEVEL = 4'h3;
	localparam logic [REG_AW-1:0] REG_IRQ_STATUS = 4'h4;
	localparam logic [REG_AW-1:0] REG_IRQ_MASK = 4'h5;

	// Interrupt event bit positions
	localparam int IRQ_W = 4;
	localparam int EV_FULL = 0;
	localparam int EV_EMPTY = 1;
	localparam int EV_WR_REFUSED = 2;
	localparam int EV_RD_REFUSED = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

	// Reset values of the pin synchronisers: channel held in reset, enables idle, second enable high
	localparam logic [SYNC_W-1:0] SYNC_RESET = 15'h003e;

	typedef enum logic {
		MODE_PROG = 1'b0,
		MODE_DUAL_WE = 1'b1
	} dcf_mode_t;

	function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction : bin2gray

	function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
		logic [PTR_W-1:0] b;
		b[PTR_W-1] = g[PTR_W-1];
		for (int i = PTR_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : gray2bin

endpackage : dcf_pkg

// ==== dcf_ram.sv ====
// Storage array of the FIFO channel with registered read data
`timescale 1ns/1ps
module dcf_ram (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic wr_en_i,
	input wire logic [dcf_pkg::ADDR_W-1:0] wr_addr_i,
	input wire logic [dcf_pkg::DATA_W-1:0] wr_data_i,
	input wire logic rd_en_i,
	input wire logic [dcf_pkg::ADDR_W-1:0] rd_addr_i,
	output logic [dcf_pkg::DATA_W-1:0] rd_data_o
);

	logic [dcf_pkg::DATA_W-1:0] mem [0:(1 << dcf_pkg::ADDR_W)-1];

	// Array itself has no reset so it maps onto block memory
	always_ff @(posedge ref_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	// Word held until the next accepted read
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= '0;
		end else if (rd_en_i) begin
			rd_data_o <= mem[rd_addr_i];
		end
	end

endmodule : dcf_ram

// ==== tb.sv ====
// Self-checking bench for the FIFO channel
`timescale 1ns/1ps
module tb;
	logic ref_clk_i;
	logic rst_i;
	logic crst_n;
	logic push;
	logic [8:0] word;
	logic load;
	logic pop;
	logic pop_one;
	logic oe_n;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [8:0] wdata;
	logic we1_n;
	logic we2;
	logic re1_n;
	logic re2_n;
	logic [8:0] rdata;
	logic rdata_oe;
	logic ef_n;
	logic ff_n;
	logic ae_n;
	logic af_n;
	logic [31:0] reg_rdata;
	logic irq;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;

	dcf_far_end u_far (.push_i(push), .word_i(word), .load_i(load), .pop_i(pop),
		.pop_one_i(pop_one), .write_data_o(wdata), .write_enable_first_n_o(we1_n),
		.write_enable_second_or_offset_load_o(we2), .read_enable_first_n_o(re1_n),
		.read_enable_second_n_o(re2_n));

	dcf_channel u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .channel_reset_n_i(crst_n),
		.write_data_in_i(wdata), .write_enable_first_n_i(we1_n),
		.write_enable_second_or_offset_load_i(we2), .read_enable_first_n_i(re1_n),
		.read_enable_second_n_i(re2_n), .output_drive_enable_n_i(oe_n),
		.read_data_out_o(rdata), .read_data_out_oe_o(rdata_oe), .empty_flag_out_n_o(ef_n),
		.full_flag_out_n_o(ff_n), .almost_empty_flag_out_n_o(ae_n),
		.almost_full_flag_out_n_o(af_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .irq_o(irq));

	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	function automatic logic [8:0] w(input int i);
		return 9'(i * 3 + 1);
	endfunction : w

	task automatic final_report;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic settle;
		repeat (10) @(posedge ref_clk_i);
		#1;
	endtask : settle

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : reg_read

	task automatic push_words(input int n, input int start);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_i);
			push <= 1'b1;
			word <= w(start + i);
		end
		@(posedge ref_clk_i);
		push <= 1'b0;
		settle();
	endtask : push_words

	// Each word appears three edges after its enables go low
	task automatic pop_check(input int n, input int start);
		@(posedge ref_clk_i);
		pop <= 1'b1;
		for (int j = 1; j <= n + 2; j++) begin
			@(posedge ref_clk_i);
			if (j == n) pop <= 1'b0;
			if (j >= 3) begin
				#1;
				chk(32'(rdata), 32'(w(start + j - 3)));
			end
		end
		settle();
	endtask : pop_check

	task automatic rd_pulse(input int n, input bit one);
		@(posedge ref_clk_i);
		if (one) pop_one <= 1'b1;
		else pop <= 1'b1;
		repeat (n) @(posedge ref_clk_i);
		pop <= 1'b0;
		pop_one <= 1'b0;
		settle();
	endtask : rd_pulse

	// Second pin level is held through the whole channel reset
	task automatic chan_reset(input logic second);
		@(posedge ref_clk_i);
		load <= second;
		crst_n <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		crst_n <= 1'b1;
		settle();
		chk({28'h0, af_n, ae_n, ff_n, ef_n}, 32'ha);
	endtask : chan_reset

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			$display("unexpected at %0t: run did not finish", $time);
			final_report();
		end
	end

	initial begin
		rst_i = 1'b1;
		crst_n = 1'b1;
		push = 1'b0;
		word = 9'h000;
		load = 1'b1;
		pop = 1'b0;
		pop_one = 1'b0;
		oe_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		settle();
		chan_reset(1'b1);
		reg_read(dcf_pkg::REG_FLAGS, 32'h1a);
		reg_write(dcf_pkg::REG_EMPTY_OFF, 32'h3);
		reg_read(dcf_pkg::REG_EMPTY_OFF, 32'h7);
		reg_read(dcf_pkg::REG_FULL_OFF, 32'h7);
		reg_read(dcf_pkg::REG_IRQ_MASK, 32'h0);
		reg_read(4'hf, 32'h0);
		// Dual enables: second pin low blocks the word
		@(posedge ref_clk_i);
		load <= 1'b0;
		push_words(1, 500);
		chk(32'(ef_n), 32'h0);
		@(posedge ref_clk_i);
		load <= 1'b1;
		push_words(7, 0);
		chk(32'({ae_n, ef_n}), 32'h1);
		push_words(1, 7);
		chk(32'(ae_n), 32'h1);
		rd_pulse(2, 1'b1);
		reg_read(dcf_pkg::REG_LEVEL, 32'h8);
		pop_check(8, 0);
		chk(32'(ef_n), 32'h0);
		@(posedge ref_clk_i);
		oe_n <= 1'b1;
		settle();
		chk(32'(rdata_oe), 32'h0);
		@(posedge ref_clk_i);
		oe_n <= 1'b0;
		settle();
		chk(32'(rdata_oe), 32'h1);
		// Fill to the full boundary and beyond
		reg_write(dcf_pkg::REG_IRQ_STATUS, 32'hf);
		push_words(248, 0);
		chk(32'({af_n, ff_n}), 32'h3);
		push_words(1, 248);
		chk(32'({af_n, ff_n}), 32'h1);
		push_words(7, 249);
		chk(32'(ff_n), 32'h0);
		push_words(1, 400);
		reg_read(dcf_pkg::REG_IRQ_STATUS, 32'h5);
		reg_write(dcf_pkg::REG_IRQ_MASK, 32'h4);
		#1;
		chk(32'(irq), 32'h1);
		reg_write(dcf_pkg::REG_IRQ_STATUS, 32'h4);
		#1;
		chk(32'(irq), 32'h0);
		reg_write(dcf_pkg::REG_IRQ_MASK, 32'h0);
		pop_check(256, 0);
		chk(32'(ef_n), 32'h0);
		rd_pulse(2, 1'b0);
		chk(32'(rdata), 32'(w(255)));
		reg_read(dcf_pkg::REG_IRQ_STATUS, 32'hb);
		// Programmable flags: load low at reset
		chan_reset(1'b0);
		reg_read(dcf_pkg::REG_FLAGS, 32'h2a);
		reg_write(dcf_pkg::REG_EMPTY_OFF, 32'h3);
		reg_read(dcf_pkg::REG_EMPTY_OFF, 32'h3);
		reg_write(dcf_pkg::REG_FULL_OFF, 32'hfc);
		reg_read(dcf_pkg::REG_FULL_OFF, 32'hfc);
		push_words(1, 600);
		chk(32'(ef_n), 32'h0);
		@(posedge ref_clk_i);
		load <= 1'b1;
		push_words(4, 20);
		chk(32'({ae_n, ef_n}), 32'h3);
		chk(32'(af_n), 32'h0);
		reg_read(dcf_pkg::REG_LEVEL, 32'h4);
		pop_check(4, 20);
		final_report();
	end
endmodule : tb
